// file: hw/vdec_pkg.sv
// Package for the voltage detect event control block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package vdec_pkg;
  localparam logic [7:0] VDEC_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] VDEC_STAT_OFFSET = 8'h04;
  localparam int VDEC_EN_BIT = 15;
  localparam int VDEC_IDLE_BIT = 13;
  localparam int VDEC_DIR_BIT = 7;
  localparam int VDEC_BG_BIT = 6;
  localparam int VDEC_REF_BIT = 5;
  localparam int VDEC_EVENT_BIT = 0;
  localparam logic [15:0] VDEC_CTRL_WMASK = 16'ha08f;
  localparam logic [15:0] VDEC_CTRL_RESET = 16'h0000;
  localparam logic [3:0] VDEC_LEVEL_EXT = 4'hf;
  localparam logic [1:0] VDEC_RESP_OKAY = 2'b00;
  localparam logic [1:0] VDEC_RESP_SLVERR = 2'b10;
endpackage : vdec_pkg

// file: hw/vdec_sync.sv
// Two-flop synchroniser with clock enable.
// Assumes the input is an asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module vdec_sync (
  input wire logic core_clk_in, // System clock.
  input wire logic rst_n_in, // Async reset, active low.
  input wire logic ce_in, // Clock enable.
  input wire logic d_in, // Asynchronous level.
  output logic q_out // Synchronised level.
);
  logic stage1;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= 1'b0;
      q_out <= 1'b0;
    end else if (ce_in) begin
      stage1 <= d_in;
      q_out <= stage1;
    end
  end
endmodule : vdec_sync
`default_nettype wire

// file: hw/vdec_top.sv
// Voltage detect event control: register slave, trip select and event flag.
// Assumes an analog comparator that takes the trip code and reports a crossing level.
`timescale 1ns/1ps
`default_nettype none
module vdec_top (
  input wire logic core_clk_in, // System clock, 100 MHz.
  input wire logic rst_n_in, // Async reset, active low.
  input wire logic ce_in, // Clock enable; freezes all state when low.
  input wire logic idle_mode_in, // Device is in idle mode.
  input wire logic cmp_above_in, // Comparator: supply at or above trip.
  input wire logic cmp_below_in, // Comparator: supply at or below trip.
  input wire logic bandgap_ok_in, // Band-gap reference stable.
  input wire logic reference_ok_in, // Internal reference stable.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic detector_power_out, // Analog detector powered.
  output logic [3:0] trip_level_select_out, // Trip code to analog.
  output logic use_external_level_out, // Route external level input.
  output logic event_flag_out // Sticky detector event flag.
);
  import vdec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic [15:0] ctrl;
  logic event_flag;
  logic above_s, below_s, bg_s, ref_s;
  logic active, hit, hit_d;
  logic aw_seen, w_seen;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] next_rdata;

  vdec_sync u_above (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .d_in(cmp_above_in), .q_out(above_s));
  vdec_sync u_below (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .d_in(cmp_below_in), .q_out(below_s));
  vdec_sync u_bg (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .d_in(bandgap_ok_in), .q_out(bg_s));
  vdec_sync u_ref (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .d_in(reference_ok_in), .q_out(ref_s));

  function automatic logic [15:0] vdec_merge(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}} & VDEC_CTRL_WMASK;
    return (old & ~m) | (d[15:0] & m);
  endfunction : vdec_merge

  ////////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order.
  assign do_write = aw_seen && w_seen && !s_axi_bvalid;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_seen <= 1'b0;
      w_seen <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= VDEC_RESP_OKAY;
    end else if (ce_in) begin
      s_axi_awready <= !aw_seen && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_seen && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_seen <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_seen <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_seen <= 1'b0;
        w_seen <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == VDEC_CTRL_OFFSET || aw_addr == VDEC_STAT_OFFSET) begin
          s_axi_bresp <= VDEC_RESP_OKAY;
        end else begin
          s_axi_bresp <= VDEC_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control storage, writable bits only.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= VDEC_CTRL_RESET;
    end else if (ce_in && do_write && aw_addr == VDEC_CTRL_OFFSET) begin
      ctrl <= vdec_merge(ctrl, w_data, w_strb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // active qualifier.
  assign active = ctrl[VDEC_EN_BIT] && !(ctrl[VDEC_IDLE_BIT] && idle_mode_in);
  assign hit = active && ref_s && (ctrl[VDEC_DIR_BIT] ? above_s : below_s);

  // sticky event, set wins over clear.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hit_d <= 1'b0;
      event_flag <= 1'b0;
    end else if (ce_in) begin
      hit_d <= hit;
      if (hit && !hit_d) begin
        event_flag <= 1'b1;
      end else if (do_write && aw_addr == VDEC_STAT_OFFSET && w_strb[0]
                   && w_data[VDEC_EVENT_BIT]) begin
        event_flag <= 1'b0;
      end
    end
  end

  // trip code passes to the analog selector through one register stage.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      detector_power_out <= 1'b0;
      trip_level_select_out <= 4'h0;
      use_external_level_out <= 1'b0;
      event_flag_out <= 1'b0;
    end else if (ce_in) begin
      detector_power_out <= active;
      trip_level_select_out <= ctrl[3:0];
      use_external_level_out <= ctrl[3:0] == VDEC_LEVEL_EXT;
      event_flag_out <= event_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read view with live stability flags.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (s_axi_araddr[7:0] == VDEC_CTRL_OFFSET) begin
      next_rdata[15:0] = ctrl;
      next_rdata[VDEC_BG_BIT] = bg_s;
      next_rdata[VDEC_REF_BIT] = ref_s;
    end else if (s_axi_araddr[7:0] == VDEC_STAT_OFFSET) begin
      next_rdata[VDEC_EVENT_BIT] = event_flag;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= VDEC_RESP_OKAY;
    end else if (ce_in) begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        if (s_axi_araddr[7:0] == VDEC_CTRL_OFFSET || s_axi_araddr[7:0] == VDEC_STAT_OFFSET) begin
          s_axi_rresp <= VDEC_RESP_OKAY;
        end else begin
          s_axi_rresp <= VDEC_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rise;
    hit && !hit_d && ce_in;
  endsequence
  property p_event_set;
    @(posedge core_clk_in) disable iff (!rst_n_in) s_rise |=> event_flag;
  endproperty
  a_event_set: assert property (p_event_set) else $error("event not set");
  property p_no_event_off;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (!ctrl[VDEC_EN_BIT] && !event_flag && ce_in) |=> !event_flag;
  endproperty
  a_no_event_off: assert property (p_no_event_off) else $error("event while off");
  property p_idle_halt;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ctrl[VDEC_IDLE_BIT] && idle_mode_in) |-> !hit;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("active in idle");
  property p_dir;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      hit |-> (ctrl[VDEC_DIR_BIT] ? above_s : below_s);
  endproperty
  a_dir: assert property (p_dir) else $error("wrong direction");
  property p_ref_gate;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (!ref_s && !event_flag && ce_in) |=> !event_flag;
  endproperty
  a_ref_gate: assert property (p_ref_gate) else $error("event while ref unstable");
  property p_ext;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (ce_in && ctrl[3:0] == VDEC_LEVEL_EXT) |=> use_external_level_out;
  endproperty
  a_ext: assert property (p_ext) else $error("external level not used");
  property p_code;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      ce_in |=> trip_level_select_out == $past(ctrl[3:0]);
  endproperty
  a_code: assert property (p_code) else $error("trip code mismatch");
  property p_unimpl;
    @(posedge core_clk_in) disable iff (!rst_n_in) (ctrl & ~VDEC_CTRL_WMASK) == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
  property p_sticky;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      (event_flag && !do_write) |=> event_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
endmodule : vdec_top
`default_nettype wire

// file: tb/vdec_analog_model.sv
// Behavioural comparator and reference circuitry facing the detector.
// Assumes trip code n sets a threshold of n supply units.
`timescale 1ns/1ps
`default_nettype none
module vdec_analog_model #(
  parameter int REF_DLY = 20 // Cycles from power-up to stable reference.
) (
  input wire logic core_clk_in, // System clock.
  input wire logic rst_n_in, // Async reset, active low.
  input wire logic power_in, // Detector powered.
  input wire logic [3:0] level_in, // Trip code.
  input wire logic ext_sel_in, // Use external level.
  input wire logic [4:0] supply_in, // Supply level.
  input wire logic [4:0] ext_level_in, // External level.
  output logic above_out, // Supply at or above trip.
  output logic below_out, // Supply at or below trip.
  output logic ref_ok_out // Reference stable.
);
  logic [4:0] thr;
  int cnt;
  assign thr = ext_sel_in ? ext_level_in : {1'h0, level_in};
  assign above_out = supply_in >= thr;
  assign below_out = supply_in <= thr;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
    end else if (!power_in) begin
      cnt <= 0;
    end else if (cnt < REF_DLY) begin
      cnt <= cnt + 1;
    end
  end
  assign ref_ok_out = cnt == REF_DLY;
endmodule : vdec_analog_model
`default_nettype wire

// file: tb/vdec_top_test.sv
// Self-checking bench for the voltage detect event control block.
// Assumes the analog model from the same folder.
`timescale 1ns/1ps
`default_nettype none
module vdec_top_test;
  import vdec_pkg::*;
  typedef struct {logic [15:0] w; logic idl; logic [4:0] s0, s1; logic [15:0] rd;
    logic ev;} vdec_row_t;
  logic clk = 0, rst_n = 0, idle = 0, bg = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic ce = 1;
  logic awrdy, wrdy, arrdy, bv, rv, pwr, ext, flag, ab, bl, rok;
  logic [31:0] aw = 0, wd = 0, ar = 0, rd, got;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] lvl;
  logic [4:0] sup = 5'h14;
  int num_errors = 0, samples_checked = 0;
  vdec_row_t rows[8] = '{
    '{16'hdf35, 1'h0, 5'h14, 5'h03, 16'h8065, 1'h1},
    '{16'h8085, 1'h0, 5'h03, 5'h05, 16'h80e5, 1'h1},
    '{16'h8085, 1'h0, 5'h03, 5'h04, 16'h80e5, 1'h0},
    '{16'h0005, 1'h0, 5'h14, 5'h03, 16'h0045, 1'h0},
    '{16'ha005, 1'h1, 5'h14, 5'h03, 16'ha045, 1'h0},
    '{16'h8005, 1'h1, 5'h14, 5'h03, 16'h8065, 1'h1},
    '{16'h800f, 1'h0, 5'h14, 5'h09, 16'h806f, 1'h1},
    '{16'h800e, 1'h0, 5'h14, 5'h0f, 16'h806e, 1'h0}};
  always #5 clk = ~clk;
  vdec_top i_vdec_top (.core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .idle_mode_in(idle),
    .cmp_above_in(ab), .cmp_below_in(bl), .bandgap_ok_in(bg), .reference_ok_in(rok),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .detector_power_out(pwr), .trip_level_select_out(lvl),
    .use_external_level_out(ext), .event_flag_out(flag));
  vdec_analog_model i_vdec_analog_model (.core_clk_in(clk), .rst_n_in(rst_n), .power_in(pwr),
    .level_in(lvl), .ext_sel_in(ext), .supply_in(sup), .ext_level_in(5'h0a), .above_out(ab),
    .below_out(bl), .ref_ok_out(rok));
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check
  task automatic bus_wr(input logic [31:0] a, d);
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (!bv);
    resp = bresp;
    br <= 1'h0;
  endtask : bus_wr
  task automatic bus_rd(input logic [31:0] a);
    @(posedge clk);
    ar <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 1'h0;
    end while (!rv);
    got = rd;
    resp = rresp;
    rr <= 1'h0;
  endtask : bus_rd
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    check({pwr, lvl, ext, flag}, 32'h0, "outputs after reset");
    bus_rd(32'h0);
    check(got, 32'h0, "control after reset");
    bg <= 1'h1;
    foreach (rows[i]) begin
      idle <= rows[i].idl;
      bus_wr(32'h0, {16'h0, rows[i].w});
      sup <= rows[i].s0;
      repeat (30) @(posedge clk);
      bus_rd(32'h0);
      check(got, {16'h0, rows[i].rd}, "control readback");
      check({pwr, lvl, ext}, {rows[i].w[15] & ~(rows[i].w[13] & rows[i].idl), rows[i].w[3:0],
        rows[i].w[3:0] == 4'hf}, "analog controls");
      bus_wr(32'h4, 32'h1);
      repeat (2) @(posedge clk);
      check(flag, 1'h0, "flag after clear");
      sup <= rows[i].s1;
      repeat (8) @(posedge clk);
      check(flag, rows[i].ev, "event flag");
      bus_rd(32'h4);
      check(got, {31'h0, rows[i].ev}, "status");
    end
    idle <= 1'h0;
    bus_wr(32'h0, 32'h8005);
    sup <= 5'h03;
    repeat (30) @(posedge clk);
    bus_wr(32'h4, 32'h1);
    repeat (4) @(posedge clk);
    check(flag, 1'h0, "no re-set while held");
    bus_wr(32'h0, 32'h0);
    sup <= 5'h14;
    bus_wr(32'h0, 32'h8005);
    sup <= 5'h03;
    repeat (3) @(posedge clk);
    sup <= 5'h14;
    repeat (30) @(posedge clk);
    check(flag, 1'h0, "crossing before reference stable");
    bg <= 1'h0;
    repeat (4) @(posedge clk);
    bus_rd(32'h0);
    check(got, 32'h8025, "band-gap unstable");
    bus_wr(32'h8, 32'hffff);
    check(resp, VDEC_RESP_SLVERR, "unmapped write");
    bus_rd(32'h8);
    check(resp, VDEC_RESP_SLVERR, "unmapped read response");
    check(got, 32'h0, "unmapped read data");
    bus_rd(32'h0);
    check(got, 32'h8025, "control kept");
    // A low clock enable must hold the synchronisers and the flag still.
    ce <= 1'h0;
    sup <= 5'h03;
    repeat (8) @(posedge clk);
    check(flag, 1'h0, "frozen by clock enable");
    ce <= 1'h1;
    repeat (8) @(posedge clk);
    check(flag, 1'h1, "event once enabled again");
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    check({pwr, lvl, ext, flag}, 32'h0, "outputs after second reset");
    bus_rd(32'h0);
    check(got, 32'h0, "control after second reset");
    end_of_test();
  end
  initial begin
    #100us;
    num_errors++;
    end_of_test();
  end
endmodule : vdec_top_test
`default_nettype wire
